// ===== logic/usb_status_irq.sv
/*
 * Top-level USB status interrupt logic: seven event flags, their enables,
 * the error summary, suspend control, bus idle and activity detection,
 * transfer status queue and device address, reached over APB.
 * Assumes serial engine event inputs are one-cycle pulses on mclk and that
 * the D+ and D- pins are asynchronous to mclk.
 */
module usb_status_irq
    import usb_irq_pkg::*;
#(
    parameter int IDLE_COUNT = IDLE_CYCLES,
    parameter int FIFO_DEPTH = XFER_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial engine events, one-cycle pulses
    input wire logic sof_evt,
    input wire logic stall_evt,
    input wire logic xfer_evt,
    input wire logic [7:0] xfer_status,
    input wire logic bus_reset_evt,
    input wire logic [7:0] err_flags,
    output logic xfer_ready,
    output logic serial_engine_clk_en,
    // Bus line pins
    input wire logic dplus_pin,
    input wire logic dminus_pin,
    // Results
    output logic [6:0] device_address_reg,
    output logic usb_cpu_irq_flag
);

    initial begin
        if (IDLE_COUNT < 2) begin
            $error("IDLE_COUNT must be at least 2");
        end
    end

    localparam int IDLE_W = $clog2(IDLE_COUNT + 1);
    localparam int WAKE_W = $clog2(WAKE_SYNC_CYCLES + 1);

    // ==========================================================
    // APB decode
    // ==========================================================
    function automatic logic hit(input logic [13:0] addr,
                                 input logic [11:0] idx);
        hit = (addr[13:2] == idx);
    endfunction

    wire sel_enable = hit(paddr, IDX_IRQ_ENABLE);
    wire sel_err_en = hit(paddr, IDX_ERR_ENABLE);
    wire sel_flags = hit(paddr, IDX_IRQ_FLAGS);
    wire sel_control = hit(paddr, IDX_CONTROL);
    wire sel_status = hit(paddr, IDX_XFER_STATUS);
    wire sel_addr = hit(paddr, IDX_DEV_ADDR);
    wire mapped = sel_enable || sel_err_en || sel_flags || sel_control
        || sel_status || sel_addr;
    wire access = psel && penable;
    wire wr = access && pwrite && mapped;
    wire [7:0] wdata = pwdata[7:0];

    // Zero-wait slave: every access ends in its first access cycle
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // ==========================================================
    // Registers
    // ==========================================================
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic [7:0] enable_r;
    logic [7:0] err_enable_r;
    logic [7:0] control_r;
    logic [6:0] dev_addr_r;
    logic irq_r;
    logic [31:0] prdata_r;

    wire suspend = control_r[BIT_SUSPEND];
    wire running = !suspend;

    // Engine gets no clock while suspended
    assign serial_engine_clk_en = running;

    // ==========================================================
    // Line state synchroniser and idle / activity detection
    // ==========================================================
    logic [1:0] line_meta_r;
    logic [1:0] line_sync_r;
    logic [1:0] line_prev_r;
    logic [IDLE_W-1:0] idle_cnt_r;
    logic idle_seen_r;
    logic act_armed_r;

    wire line_change = (line_sync_r != line_prev_r);
    wire idle_done = (idle_cnt_r == IDLE_W'(IDLE_COUNT - 1));
    // Engine is not clocked in suspend, so no idle event then
    wire idle_evt = idle_done && !idle_seen_r && running;
    // Line activity is watched even during suspend
    wire act_evt = line_change && act_armed_r;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            // Reset to the idle J level so no false change follows reset
            line_meta_r <= 2'h2;
            line_sync_r <= 2'h2;
            line_prev_r <= 2'h2;
        end else begin
            line_meta_r <= {dplus_pin, dminus_pin};
            line_sync_r <= line_meta_r;
            line_prev_r <= line_sync_r;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            idle_cnt_r <= '0;
            idle_seen_r <= 1'b0;
        end else if (line_change) begin
            idle_cnt_r <= '0;
            idle_seen_r <= 1'b0;
        end else if (!idle_done) begin
            idle_cnt_r <= idle_cnt_r + IDLE_W'(1);
        end else if (running) begin
            idle_seen_r <= 1'b1;
        end
    end

    // Only an idle detection re-arms the activity event
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            act_armed_r <= 1'b0;
        end else if (idle_evt) begin
            act_armed_r <= 1'b1;
        end else if (act_evt) begin
            act_armed_r <= 1'b0;
        end
    end

    // ==========================================================
    // Wake-up synchronisation window
    // ==========================================================
    logic [WAKE_W-1:0] wake_cnt_r;
    logic suspend_q_r;
    wire wake_edge = suspend_q_r && !suspend;
    wire act_clear_blocked = suspend || wake_edge
        || (wake_cnt_r != '0);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            suspend_q_r <= 1'b0;
            wake_cnt_r <= '0;
        end else begin
            suspend_q_r <= suspend;
            if (wake_edge) begin
                wake_cnt_r <= WAKE_W'(WAKE_SYNC_CYCLES);
            end else if (wake_cnt_r != '0) begin
                wake_cnt_r <= wake_cnt_r - WAKE_W'(1);
            end
        end
    end

    // ==========================================================
    // Transfer status queue
    // ==========================================================
    logic head_valid_r;
    logic head_seen_r;
    logic [7:0] head_data_r;
    logic fifo_full;

    wire xfer_push = xfer_evt && running;
    // Clearing a set done flag pops the queue
    wire flags_wr = wr && sel_flags;
    wire xfer_pop = flags_wr && flags_r[BIT_TRANSFER_DONE]
        && !wdata[BIT_TRANSFER_DONE];
    wire xfer_new = head_valid_r && !head_seen_r;

    assign xfer_ready = !fifo_full;

    xfer_status_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_status_fifo (
        .mclk(mclk),
        .rst_b(rst_b),
        .push(xfer_push),
        .push_data(xfer_status),
        .pop(xfer_pop),
        .full(fifo_full),
        .head_valid_r(head_valid_r),
        .head_data_r(head_data_r)
    );

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            head_seen_r <= 1'b0;
        end else begin
            head_seen_r <= head_valid_r;
        end
    end

    // ==========================================================
    // Flag update: hardware set wins over software clear
    // ==========================================================
    wire err_summary = |(err_flags & err_enable_r);
    logic [7:0] hw_set;
    logic [7:0] sw_val;

    always_comb begin
        hw_set = 8'h00;
        hw_set[BIT_FRAME_START] = sof_evt && running;
        hw_set[BIT_STALL_SENT] = stall_evt && running;
        hw_set[BIT_BUS_IDLE] = idle_evt;
        hw_set[BIT_TRANSFER_DONE] = xfer_new;
        hw_set[BIT_BUS_ACTIVITY] = act_evt;
        hw_set[BIT_BUS_RESET] = bus_reset_evt && running;
    end

    always_comb begin
        sw_val = flags_r;
        if (flags_wr) begin
            // Writes of one set, writes of zero clear
            sw_val = wdata;
            if (act_clear_blocked) begin
                sw_val[BIT_BUS_ACTIVITY] = flags_r[BIT_BUS_ACTIVITY]
                    | wdata[BIT_BUS_ACTIVITY];
            end
        end
    end

    always_comb begin
        // Flags set regardless of enables so software can poll
        flags_nxt = (sw_val | hw_set) & FLAGS_WR_MASK;
        flags_nxt[BIT_ERROR_SUMMARY] = err_summary;
        flags_nxt[7] = 1'b0;
    end

    wire [7:0] enable_nxt = (wr && sel_enable) ? (wdata & ENABLE_MASK)
        : enable_r;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            flags_r <= FLAGS_RESET;
            enable_r <= ENABLE_RESET;
            irq_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            enable_r <= enable_nxt;
            // Level request, tracks flags and enables together
            irq_r <= |(flags_nxt & enable_nxt);
        end
    end

    assign usb_cpu_irq_flag = irq_r;

    // ==========================================================
    // Control, error enable and device address
    // ==========================================================
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            control_r <= CONTROL_RESET;
            err_enable_r <= ERR_ENABLE_RESET;
        end else begin
            if (wr && sel_control) begin
                control_r <= wdata & (8'h01 << BIT_SUSPEND);
            end
            if (wr && sel_err_en) begin
                err_enable_r <= wdata & ERR_ENABLE_MASK;
            end
        end
    end

    // Bus reset beats a software write in the same cycle
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            dev_addr_r <= DEV_ADDR_RESET;
        end else if (bus_reset_evt && running) begin
            dev_addr_r <= DEV_ADDR_RESET;
        end else if (wr && sel_addr) begin
            dev_addr_r <= wdata[6:0] & DEV_ADDR_MASK;
        end
    end

    assign device_address_reg = dev_addr_r;

    // ==========================================================
    // Read data
    // ==========================================================
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        if (sel_flags) begin
            rd_byte = flags_r;
        end else if (sel_enable) begin
            rd_byte = enable_r;
        end else if (sel_err_en) begin
            rd_byte = err_enable_r;
        end else if (sel_control) begin
            rd_byte = control_r;
        end else if (sel_status) begin
            rd_byte = head_data_r;
        end else if (sel_addr) begin
            rd_byte = {1'b0, dev_addr_r};
        end
    end

    // Read data settles in the setup cycle, valid in the access cycle
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= {24'h00_0000, rd_byte};
        end
    end

    assign prdata = prdata_r;

endmodule

// ===== shared/usb_irq_pkg.sv
/*
 * Constants for the USB status interrupt block: register indices, field
 * positions, reset values and timing counts.
 * Assumes a 20 MHz mclk and an APB master with 32-bit data.
 */
package usb_irq_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    // ==========================================================
    localparam logic [11:0] IDX_IRQ_ENABLE = 12'hF36;
    localparam logic [11:0] IDX_ERR_ENABLE = 12'hF37;
    localparam logic [11:0] IDX_IRQ_FLAGS = 12'hF62;
    localparam logic [11:0] IDX_CONTROL = 12'hF70;
    localparam logic [11:0] IDX_XFER_STATUS = 12'hF71;
    localparam logic [11:0] IDX_DEV_ADDR = 12'hF72;

    // ==========================================================
    // Flag, enable and control bit positions
    // ==========================================================
    localparam int BIT_FRAME_START = 6;
    localparam int BIT_STALL_SENT = 5;
    localparam int BIT_BUS_IDLE = 4;
    localparam int BIT_TRANSFER_DONE = 3;
    localparam int BIT_BUS_ACTIVITY = 2;
    localparam int BIT_ERROR_SUMMARY = 1;
    localparam int BIT_BUS_RESET = 0;
    localparam int BIT_SUSPEND = 1;

    // Writable flag bits: all but bit 7 and the error summary
    localparam logic [7:0] FLAGS_WR_MASK = 8'h7D;
    localparam logic [7:0] ENABLE_MASK = 8'h7F;
    localparam logic [7:0] ERR_ENABLE_MASK = 8'h9F;
    localparam logic [6:0] DEV_ADDR_MASK = 7'h7F;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] ERR_ENABLE_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [6:0] DEV_ADDR_RESET = 7'h00;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_FREQ_KHZ = 20000;
    localparam int IDLE_TIME_MS = 3;
    localparam int IDLE_CYCLES = IDLE_TIME_MS * CLK_FREQ_KHZ;
    localparam int WAKE_SYNC_CYCLES = 4;
    localparam int XFER_FIFO_DEPTH = 4;

endpackage

// ===== logic/xfer_status_fifo.sv
/*
 * Small FIFO holding transfer status words (endpoint information).
 * Assumes push and pop come from logic on the same clock; the head word
 * comes out of a register one cycle after it becomes the head.
 */
module xfer_status_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic full,
    output logic head_valid_r,
    output logic [WIDTH-1:0] head_data_r
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("fifo depth must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] count_r;
    wire empty = (count_r == '0);
    wire do_push = push && !full;
    wire do_pop = pop && !empty;

    assign full = (count_r == (PW + 1)'(DEPTH));

    always_ff @(posedge mclk) begin
        if (do_push) begin
            mem[wr_ptr_r] <= push_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            head_valid_r <= 1'b0;
            head_data_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_r + PW'(do_push);
            rd_ptr_r <= rd_ptr_r + PW'(do_pop);
            count_r <= count_r + (PW + 1)'(do_push) - (PW + 1)'(do_pop);
            // Low for a cycle after a pop so each entry shows as new
            head_valid_r <= !empty && !pop;
            head_data_r <= mem[rd_ptr_r];
        end
    end

endmodule

// ===== testbench/usb_status_irq_asserts.sv
/* Port checker for usb_status_irq.
   Assumes one mclk domain and the zero-wait APB slave. */
module usb_status_irq_asserts
    import usb_irq_pkg::*;
#(
    parameter int IDLE_COUNT = IDLE_CYCLES,
    parameter int FIFO_DEPTH = XFER_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sof_evt,
    input wire logic bus_reset_evt,
    input wire logic [7:0] err_flags,
    input wire logic serial_engine_clk_en,
    input wire logic [6:0] device_address_reg,
    input wire logic usb_cpu_irq_flag
);
    // ==========================================================
    // Decode
    // ==========================================================
    wire logic [11:0] idx = paddr[13:2];
    wire logic acc = psel && penable;
    wire logic wr = acc && pwrite;
    wire logic rd = acc && !pwrite;
    wire logic hit = idx inside {IDX_IRQ_ENABLE, IDX_ERR_ENABLE,
        IDX_IRQ_FLAGS, IDX_CONTROL, IDX_XFER_STATUS, IDX_DEV_ADDR};
    wire logic rst_wins = bus_reset_evt && serial_engine_clk_en;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // ==========================================================
    // Properties
    // ==========================================================
    chk_flag_top_zero:
    assert property (rd && idx == IDX_IRQ_FLAGS |-> !prdata[7])
        else $error("flag bit 7 read as one");
    chk_enable_top_zero:
    assert property (rd && idx == IDX_IRQ_ENABLE |-> prdata[31:7] == 25'h0)
        else $error("enable read has bits above 6");
    chk_unmapped_err:
    assert property (acc && !hit |-> pslverr && pready)
        else $error("unmapped access not refused");
    chk_err_access_only:
    assert property (!acc |-> !pslverr)
        else $error("slave error outside access");
    chk_reset_clears_addr:
    assert property (rst_wins |=> device_address_reg == 7'h00)
        else $error("bus reset left address set");
    chk_addr_write:
    assert property (wr && idx == IDX_DEV_ADDR && !rst_wins
        |=> device_address_reg == $past(pwdata[6:0]))
        else $error("address write not stored");
    chk_suspend_gates_clk:
    assert property (wr && idx == IDX_CONTROL
        |=> serial_engine_clk_en == !$past(pwdata[1]))
        else $error("engine clock enable wrong");
    chk_irq_level_holds:
    assert property (usb_cpu_irq_flag && !wr && err_flags == 8'h00
        && $past(err_flags) == 8'h00 |=> usb_cpu_irq_flag)
        else $error("request dropped with no write");
    chk_err_summary_live:
    assert property (rd && idx == IDX_IRQ_FLAGS && err_flags == 8'h00
        && $past(err_flags) == 8'h00 && $past(err_flags, 2) == 8'h00
        |-> !prdata[1])
        else $error("summary set with no error");

    cov_irq_rise: cover property ($rose(usb_cpu_irq_flag));
    cov_refused: cover property (acc && pslverr);
    cov_bus_reset: cover property (rst_wins ##1 device_address_reg == 7'h00);
endmodule

bind usb_status_irq usb_status_irq_asserts #(
    .IDLE_COUNT(IDLE_COUNT), .FIFO_DEPTH(FIFO_DEPTH)
) u_chk (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sof_evt(sof_evt),
    .bus_reset_evt(bus_reset_evt), .err_flags(err_flags),
    .serial_engine_clk_en(serial_engine_clk_en),
    .device_address_reg(device_address_reg),
    .usb_cpu_irq_flag(usb_cpu_irq_flag)
);

// ===== testbench/usb_line_model.sv
/* Model of the D+ and D- lines as the host drives them.
   Assumes mclk as timebase; traffic high toggles the pair. */
module usb_line_model (
    input wire logic mclk,
    input wire logic traffic,
    output logic dplus_pin,
    output logic dminus_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Line state
    // ==========================================================
    // Idle is J; traffic alternates J and K so every cycle changes
    initial begin
        dplus_pin = 1'b1;
        dminus_pin = 1'b0;
    end
    always @(posedge mclk) begin
        dplus_pin <= traffic ? !dplus_pin : 1'b1;
        dminus_pin <= traffic ? dplus_pin : 1'b0;
    end
endmodule

// ===== testbench/tb_top.sv
/* Self-checking bench for usb_status_irq.
   Assumes the zero-wait APB slave and a short idle count. */
module tb_top
    import usb_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int IDLE_N = 50;
    typedef struct packed {
        logic [11:0] idx;
        logic [7:0] wd;
        logic [7:0] exp;
        logic err;
    } row_type;
    row_type rows [0:7] = '{
        '{IDX_IRQ_ENABLE, 8'hFF, 8'h7F, 1'b0},
        '{IDX_ERR_ENABLE, 8'hFF, 8'h9F, 1'b0},
        '{IDX_DEV_ADDR, 8'hFF, 8'h7F, 1'b0},
        '{IDX_CONTROL, 8'h00, 8'h00, 1'b0},
        '{IDX_IRQ_FLAGS, 8'hFF, 8'h7D, 1'b0},
        '{IDX_IRQ_FLAGS, 8'h00, 8'h00, 1'b0},
        '{IDX_IRQ_ENABLE, 8'h00, 8'h00, 1'b0},
        '{12'h001, 8'hFF, 8'h00, 1'b1}};
    logic mclk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic sof_evt, stall_evt, xfer_evt, bus_reset_evt, xfer_ready;
    logic [7:0] xfer_status, err_flags;
    logic clk_en, dplus, dminus, irq, traffic, re;
    logic [6:0] addr;
    int bad_count = 0;
    int num_checks = 0;

    usb_status_irq #(.IDLE_COUNT(IDLE_N), .FIFO_DEPTH(4)) DUT (
        .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sof_evt(sof_evt), .stall_evt(stall_evt), .xfer_evt(xfer_evt),
        .xfer_status(xfer_status), .bus_reset_evt(bus_reset_evt),
        .err_flags(err_flags), .xfer_ready(xfer_ready),
        .serial_engine_clk_en(clk_en), .dplus_pin(dplus),
        .dminus_pin(dminus), .device_address_reg(addr),
        .usb_cpu_irq_flag(irq));
    usb_line_model host (.mclk(mclk), .traffic(traffic),
        .dplus_pin(dplus), .dminus_pin(dminus));

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic apb(input logic w, input logic [11:0] i,
                       input logic [7:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] i, input logic [7:0] exp);
        apb(1'b0, i, 8'h00);
        cmp_word(rv, {24'h0, exp});
    endtask
    task automatic evt(input logic [2:0] v);
        {sof_evt, stall_evt, bus_reset_evt} <= v;
        @(posedge mclk);
        {sof_evt, stall_evt, bus_reset_evt} <= 3'b000;
        repeat (2) @(posedge mclk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ==========================================================
    // Clock, watchdog, sequence
    // ==========================================================
    initial begin
        mclk = 1'b0;
        forever #25 mclk = !mclk;
    end
    initial begin
        repeat (6000) @(posedge mclk);
        bad_count++;
        test_done();
    end
    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
        {sof_evt, stall_evt, xfer_evt, bus_reset_evt} = 4'h0;
        xfer_status = 8'h00;
        err_flags = 8'h00;
        traffic = 1'b1;
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        cmp_bit(irq, 1'b0);
        cmp_bit(clk_en, 1'b1);
        cmp_word({25'h0, addr}, 32'h0);
        rdc(IDX_IRQ_FLAGS, FLAGS_RESET);
        rdc(IDX_IRQ_ENABLE, ENABLE_RESET);
        foreach (rows[k]) begin
            apb(1'b1, rows[k].idx, rows[k].wd);
            cmp_bit(re, rows[k].err);
            rdc(rows[k].idx, rows[k].exp);
            cmp_bit(re, rows[k].err);
        end
        // Events land with every interrupt enable off
        apb(1'b1, IDX_DEV_ADDR, 8'h15);
        evt(3'b111);
        cmp_word({25'h0, addr}, 32'h0);
        rdc(IDX_IRQ_FLAGS, 8'h61);
        cmp_bit(irq, 1'b0);
        apb(1'b1, IDX_IRQ_ENABLE, 8'h20);
        @(posedge mclk);
        cmp_bit(irq, 1'b1);
        apb(1'b1, IDX_IRQ_FLAGS, 8'h41);
        @(posedge mclk);
        cmp_bit(irq, 1'b0);
        rdc(IDX_IRQ_FLAGS, 8'h41);
        apb(1'b1, IDX_IRQ_FLAGS, 8'h00);
        // Error summary follows the enabled errors only
        err_flags <= 8'h08;
        rdc(IDX_IRQ_FLAGS, 8'h02);
        apb(1'b1, IDX_IRQ_FLAGS, 8'h00);
        rdc(IDX_IRQ_FLAGS, 8'h02);
        apb(1'b1, IDX_ERR_ENABLE, 8'h01);
        rdc(IDX_IRQ_FLAGS, 8'h00);
        err_flags <= 8'h00;
        // Two back-to-back transfers queue their status
        xfer_evt <= 1'b1;
        xfer_status <= 8'hA5;
        @(posedge mclk);
        xfer_status <= 8'h3C;
        @(posedge mclk);
        xfer_evt <= 1'b0;
        repeat (3) @(posedge mclk);
        cmp_bit(xfer_ready, 1'b1);
        rdc(IDX_IRQ_FLAGS, 8'h08);
        rdc(IDX_XFER_STATUS, 8'hA5);
        apb(1'b1, IDX_IRQ_FLAGS, 8'h00);
        repeat (3) @(posedge mclk);
        rdc(IDX_IRQ_FLAGS, 8'h08);
        rdc(IDX_XFER_STATUS, 8'h3C);
        apb(1'b1, IDX_IRQ_FLAGS, 8'h00);
        repeat (3) @(posedge mclk);
        rdc(IDX_IRQ_FLAGS, 8'h00);
        // Idle while running, then suspend, then wake on line activity
        traffic <= 1'b0;
        repeat (IDLE_N + 10) @(posedge mclk);
        rdc(IDX_IRQ_FLAGS, 8'h10);
        apb(1'b1, IDX_IRQ_ENABLE, 8'h04);
        apb(1'b1, IDX_DEV_ADDR, 8'h15);
        apb(1'b1, IDX_CONTROL, 8'h02);
        @(posedge mclk);
        cmp_bit(clk_en, 1'b0);
        evt(3'b111);
        rdc(IDX_IRQ_FLAGS, 8'h10);
        cmp_word({25'h0, addr}, 32'h15);
        traffic <= 1'b1;
        repeat (6) @(posedge mclk);
        rdc(IDX_IRQ_FLAGS, 8'h14);
        cmp_bit(irq, 1'b1);
        apb(1'b1, IDX_IRQ_FLAGS, 8'h10);
        rdc(IDX_IRQ_FLAGS, 8'h14);
        apb(1'b1, IDX_CONTROL, 8'h00);
        apb(1'b1, IDX_IRQ_FLAGS, 8'h10);
        rdc(IDX_IRQ_FLAGS, 8'h14);
        for (int n = 0; n < 8 && rv[2] === 1'b1; n++) begin
            apb(1'b1, IDX_IRQ_FLAGS, 8'h10);
            apb(1'b0, IDX_IRQ_FLAGS, 8'h00);
        end
        repeat (100) @(posedge mclk);
        rdc(IDX_IRQ_FLAGS, 8'h10);
        cmp_bit(irq, 1'b0);
        test_done();
    end
endmodule
